// *** rtl/ppe_consts.vh ***
`ifndef PPE_CONSTS_VH
`define PPE_CONSTS_VH
// port modes
`define PPE_MODE_COMPAT   3'h0
`define PPE_MODE_FIFO     3'h5
`define PPE_MODE_ECP      3'h3
`define PPE_MODE_EPP      3'h4
// timing figures in ns and clock period
`define PPE_CLK_NS        50
`define PPE_WAIT_FILT_NS  50
`define PPE_SETUP_NS      100
`define PPE_EPP_TMO_NS    10000
// drive change settle cycles between enable steps
`define PPE_DRV_SETTLE    2
`define PPE_DATA_W        8
`define PPE_FIFO_DEPTH    8
`endif

// *** rtl/ppe_fifo.v ***
`timescale 1ns/1ps
module ppe_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk_i,
    input  wire             arst_n_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    // handshake and occupancy flags
    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    ////////////////////////////////////////////////////////////////////////////
    // storage written by index
    always @(posedge sys_clk_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end

    // pointers and count
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// *** rtl/ppe_wait_filt.v ***
`timescale 1ns/1ps
`include "ppe_consts.vh"
module ppe_wait_filt #(
    parameter CYC = 1
) (
    input  wire sys_clk_i,
    input  wire arst_n_i,
    input  wire raw_i,
    output reg  settled_o
);
    reg       sync_a;
    reg       sync_b;
    reg       last;
    reg [7:0] quiet;

    ////////////////////////////////////////////////////////////////////////////
    // two-stage sync, then level accepted after CYC quiet cycles
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync_a    <= 1'b1;
            sync_b    <= 1'b1;
            last      <= 1'b1;
            quiet     <= 8'h00;
            settled_o <= 1'b1;
        end
        else
        begin
            sync_a <= raw_i;
            sync_b <= sync_a;
            last   <= sync_b;
            if (sync_b != last)
                quiet <= 8'h00;
            else if (quiet < CYC[7:0])
                quiet <= quiet + 8'h01;
            else
                settled_o <= last; // R15
        end
    end
endmodule

// *** rtl/ppe_port.v ***
// How it works
// R1: fifo mode ignores ack line; next byte starts only on busy low
// R2: forward idle holds host clock high, peripheral keeps busy low
// R3: peripheral may raise reverse request any time during forward phase
// R4: forward strobe falls only after peripheral ack is seen low
// R5: data set up on lines before host clock falls
// R6: host clock returns high only after peripheral ack goes high
// R7: peripheral latches byte then drops ack, ending forward transfer
// R8: reverse idle keeps host ack line low
// R9: host ack driven low only after previous byte is accepted
// R10: peripheral drops its clock with data already stable
// R11: host raises ack line after peripheral clock falls when ready
// R12: peripheral clock rise captures byte, host ack returns low
// R13: ecp mode drives push-pull, compat mode open-collector
// R14: drive type changes without output glitches
// R15: wait line settled only after 50 ns without transitions
// R16: write-direction line high unless epp write in progress
// R17: software clears direction bit before an epp write
// R18: software sets direction bit before an epp read
// R19: iochrdy held low during epp cycle until handshake or timeout
`timescale 1ns/1ps
`include "ppe_consts.vh"
module ppe_port #(
    parameter DATA_W     = `PPE_DATA_W,
    parameter FIFO_DEPTH = `PPE_FIFO_DEPTH,
    parameter TMO_CYC    = (`PPE_EPP_TMO_NS / `PPE_CLK_NS)
) (
    input  wire              sys_clk_i,
    input  wire              arst_n_i,
    input  wire [2:0]        mode_i,
    input  wire              direction_control_bit_i,
    input  wire              rev_req_i,
    input  wire [DATA_W-1:0] tx_data_i,
    input  wire              tx_valid_i,
    output reg               tx_ready_o,
    output reg  [DATA_W-1:0] rx_data_o,
    output reg               rx_valid_o,
    input  wire              nior_i,
    input  wire              niow_i,
    output reg               iochrdy_o,
    output reg               epp_timeout_o,
    input  wire [DATA_W-1:0] pd_i,
    output reg  [DATA_W-1:0] pd_o,
    output reg               pd_oe_o,
    output reg               host_clk_o,
    output reg               host_clk_oe_o,
    output reg               host_ack_line_o,
    output reg               host_ack_line_oe_o,
    output reg               nwrite_o,
    input  wire              busy_i,
    input  wire              nack_i,
    input  wire              nperiph_req_i,
    input  wire              nwait_i,
    output reg               periph_req_o
);
    // cycle counts rounded up from the ns figures
    localparam FILT_CYC  = (`PPE_WAIT_FILT_NS + `PPE_CLK_NS - 1) / `PPE_CLK_NS;
    localparam SETUP_CYC = (`PPE_SETUP_NS + `PPE_CLK_NS - 1) / `PPE_CLK_NS;
    localparam FIFO_AW   = $clog2(FIFO_DEPTH);
    // states
    localparam S_FIDLE  = 4'h0;
    localparam S_FSETUP = 4'h1;
    localparam S_FSTRB  = 4'h2;
    localparam S_FREL   = 4'h3;
    localparam S_RIDLE  = 4'h4;
    localparam S_RACK   = 4'h5;
    localparam S_RCAP   = 4'h6;
    localparam S_EWAIT  = 4'h7;
    localparam S_EDONE  = 4'h8;
    localparam S_CWAIT  = 4'h9;

    function [15:0] sat_inc;
        input [15:0] v;
        begin
            sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
        end
    endfunction

    reg  [3:0]        state;
    reg  [15:0]       cnt;
    reg  [1:0]        busy_s;
    reg  [1:0]        nack_s;
    reg  [1:0]        nreq_s;
    reg  [1:0]        nior_s;
    reg  [1:0]        niow_s;
    reg  [DATA_W-1:0] pd_s0;
    reg  [DATA_W-1:0] pd_s1;
    reg  [2:0]        drv_q;
    reg               ecp_drv;
    wire              wait_settled;
    wire [DATA_W-1:0] f_data;
    wire              f_valid;
    wire              f_in_ready;
    reg               f_pop;
    wire              busy   = busy_s[1];
    wire              nack   = nack_s[1];
    wire              is_ecp = (mode_i == `PPE_MODE_ECP);
    // next pin levels, so an open-collector enable moves with its level
    wire              strobe_fall   = (state == S_FSETUP) && (cnt >= SETUP_CYC - 1);
    wire              strobe_rise   = (state == S_FIDLE) || ((state == S_FSTRB) && busy);
    wire              next_host_clk = ~strobe_fall & (strobe_rise | host_clk_o);
    wire              next_host_ack = (state == S_RACK) | (host_ack_line_o & (state != S_FIDLE)
                                      & (state != S_RIDLE) & (state != S_RCAP));

    ////////////////////////////////////////////////////////////////////////////
    // forward data buffer
    ppe_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .arst_n_i    (arst_n_i),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (f_in_ready),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop)
    );

    // peripheral wait filter
    ppe_wait_filt #(.CYC(FILT_CYC)) u_wait (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .raw_i     (nwait_i),
        .settled_o (wait_settled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            busy_s <= 2'h0;
            nack_s <= 2'h3;
            nreq_s <= 2'h3;
            nior_s <= 2'h3;
            niow_s <= 2'h3;
            pd_s0  <= {DATA_W{1'b0}};
            pd_s1  <= {DATA_W{1'b0}};
        end
        else
        begin
            busy_s <= {busy_s[0], busy_i};
            nack_s <= {nack_s[0], nack_i};
            nreq_s <= {nreq_s[0], nperiph_req_i};
            nior_s <= {nior_s[0], nior_i};
            niow_s <= {niow_s[0], niow_i};
            pd_s0  <= pd_i;
            pd_s1  <= pd_s0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive type sequencing: level first, enable after settle
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            drv_q   <= 3'h0;
            ecp_drv <= 1'b0;
        end
        else if (ecp_drv != is_ecp)
        begin
            if (drv_q == `PPE_DRV_SETTLE)
            begin
                ecp_drv <= is_ecp; // R13 R14
                drv_q   <= 3'h0;
            end
            else
                drv_q <= drv_q + 3'h1;
        end
        else
            drv_q <= 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers: open-collector enables only pull low
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            host_clk_oe_o      <= 1'b0;
            host_ack_line_oe_o <= 1'b0;
            tx_ready_o         <= 1'b0;
            periph_req_o       <= 1'b0;
        end
        else
        begin
            host_clk_oe_o      <= ecp_drv | ~next_host_clk; // R13
            host_ack_line_oe_o <= ecp_drv | ~next_host_ack; // R13
            tx_ready_o         <= f_in_ready;
            periph_req_o       <= ~nreq_s[1];                 // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer state machine
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state           <= S_FIDLE;
            cnt             <= 16'h0000;
            f_pop           <= 1'b0;
            pd_o            <= {DATA_W{1'b0}};
            pd_oe_o         <= 1'b0;
            host_clk_o      <= 1'b1;
            host_ack_line_o <= 1'b0;
            nwrite_o        <= 1'b1;
            iochrdy_o       <= 1'b1;
            epp_timeout_o   <= 1'b0;
            rx_data_o       <= {DATA_W{1'b0}};
            rx_valid_o      <= 1'b0;
        end
        else
        begin
            f_pop      <= 1'b0;
            rx_valid_o <= 1'b0;
            case (state)
            // idle: start an epp cycle, a reverse phase or a forward byte
            S_FIDLE:
            begin
                host_clk_o      <= 1'b1; // R2
                host_ack_line_o <= 1'b0;
                nwrite_o        <= 1'b1; // R16
                iochrdy_o       <= 1'b1;
                cnt             <= 16'h0000;
                if (mode_i == `PPE_MODE_EPP && (!nior_s[1] || !niow_s[1]))
                begin
                    iochrdy_o     <= 1'b0; // R19
                    epp_timeout_o <= 1'b0;
                    pd_oe_o       <= !niow_s[1] & ~direction_control_bit_i; // R17 R18
                    pd_o          <= tx_data_i;
                    nwrite_o      <= !(!niow_s[1] && !direction_control_bit_i); // R16
                    state         <= S_EWAIT;
                end
                else if (is_ecp && rev_req_i && !nreq_s[1])
                begin
                    pd_oe_o <= 1'b0;
                    state   <= S_RIDLE;
                end
                else if (f_valid && !f_pop && !busy && mode_i != `PPE_MODE_EPP) // R1 R4
                begin
                    pd_o    <= f_data; // R5
                    pd_oe_o <= 1'b1;
                    f_pop   <= 1'b1;
                    state   <= S_FSETUP;
                end
            end
            // forward data setup before the strobe falls
            S_FSETUP:
            begin
                cnt <= sat_inc(cnt);
                if (cnt >= SETUP_CYC - 1) // R5
                begin
                    host_clk_o <= 1'b0;
                    cnt        <= 16'h0000;
                    state      <= S_FSTRB;
                end
            end
            // strobe low until the peripheral acknowledges
            S_FSTRB:
            begin
                if (busy) // R6
                begin
                    host_clk_o <= 1'b1;
                    state      <= S_FREL;
                end
            end
            // strobe high, wait for the peripheral to go idle
            S_FREL:
            begin
                if (!busy) // R7 R1
                    state <= S_FIDLE;
            end
            // reverse idle, wait for the peripheral clock to fall
            S_RIDLE:
            begin
                host_ack_line_o <= 1'b0; // R8 R9
                if (!rev_req_i)
                    state <= S_FIDLE;
                else if (!nack) // R10
                    state <= S_RACK;
            end
            // host ack high, capture on peripheral clock rise
            S_RACK:
            begin
                host_ack_line_o <= 1'b1; // R11
                if (nack) // R12
                begin
                    rx_data_o  <= pd_s1;
                    rx_valid_o <= 1'b1;
                    state      <= S_RCAP;
                end
            end
            // byte taken, return host ack low
            S_RCAP:
            begin
                host_ack_line_o <= 1'b0; // R12
                state           <= S_RIDLE;
            end
            // epp cycle stretched until wait settles low or time runs out
            S_EWAIT:
            begin
                cnt <= sat_inc(cnt);
                if (!wait_settled) // R15
                begin
                    if (!pd_oe_o)
                        rx_data_o <= pd_s1;
                    rx_valid_o <= ~pd_oe_o;
                    iochrdy_o  <= 1'b1;
                    state      <= S_EDONE;
                end
                else if (cnt >= TMO_CYC - 1) // R19
                begin
                    epp_timeout_o <= 1'b1;
                    iochrdy_o     <= 1'b1;
                    state         <= S_EDONE;
                end
            end
            // wait for the host strobes to end
            S_EDONE:
            begin
                if (nior_s[1] && niow_s[1])
                begin
                    nwrite_o <= 1'b1; // R16
                    pd_oe_o  <= 1'b0;
                    state    <= S_CWAIT;
                end
            end
            // one spare cycle before the next cycle may start
            S_CWAIT:
            begin
                state <= S_FIDLE;
            end
            default:
            begin
                state <= S_FIDLE;
            end
            endcase
        end
    end
endmodule

// *** test/ppe_port_properties.sv ***
`timescale 1ns/1ps
`include "ppe_consts.vh"
module ppe_port_properties #(
    parameter DATA_W = 8
) (
    input logic              sys_clk_i,
    input logic              arst_n_i,
    input logic [2:0]        mode_i,
    input logic              niow_i,
    input logic              busy_i,
    input logic              nack_i,
    input logic              nwait_i,
    input logic [DATA_W-1:0] pd_o,
    input logic              pd_oe_o,
    input logic              host_clk_o,
    input logic              host_clk_oe_o,
    input logic              host_ack_line_o,
    input logic              nwrite_o,
    input logic              iochrdy_o,
    input logic              epp_timeout_o,
    input logic              rx_valid_o
);
    localparam int TMO_MAX = 220;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////
    // forward interlock: strobe waits for idle peripheral, data leads the strobe
    strobe_when_idle_a: assert property ($fell(host_clk_o) |-> !$past(busy_i) && !$past(busy_i, 5))
        else $error("strobe fell while busy");
    data_setup_a: assert property ($fell(host_clk_o) |-> $past(pd_oe_o) && $past(pd_o) == pd_o)
        else $error("data not set up before strobe");
    strobe_return_a: assert property ($rose(host_clk_o) |-> $past(busy_i, 2))
        else $error("strobe returned before ack");
    // reverse interlock
    rev_ack_rise_a: assert property ($rose(host_ack_line_o) |-> !$past(nack_i, 2))
        else $error("host ack rose early");
    rev_ack_drop_a: assert property (rx_valid_o && mode_i == `PPE_MODE_ECP
        |-> ##[0:1] !host_ack_line_o) else $error("host ack not dropped");
    // a drive change alone never moves the pin level
    drive_swap_a: assert property ($changed(host_clk_oe_o) && $stable(host_clk_o) |-> host_clk_o)
        else $error("strobe drive swap glitch");
    // epp direction and ready handling
    write_dir_idle_a: assert property (niow_i [*5] |-> nwrite_o)
        else $error("write direction active without write");
    epp_stretch_a: assert property ($fell(iochrdy_o) |-> ##[1:TMO_MAX] iochrdy_o)
        else $error("ready held low too long");
    wait_settle_a: assert property ($rose(iochrdy_o) && $past(nwait_i, 3)
        |-> ##[0:1] epp_timeout_o) else $error("ready rose on unsettled wait");
    cover property ($rose(host_clk_o));
    cover property ($rose(rx_valid_o) && mode_i == `PPE_MODE_ECP);
    cover property ($rose(epp_timeout_o));
endmodule

// *** test/ppe_periph_model.sv ***
`timescale 1ns/1ps
module ppe_periph_model (
    input  wire        sys_clk_i,
    input  wire        host_clk_i,
    input  wire        host_ack_i,
    input  wire        iochrdy_i,
    input  wire  [7:0] hdata_i,
    input  wire        rev_i,
    input  wire        send_i,
    input  wire  [7:0] data_i,
    input  wire        stall_i,
    input  wire  [3:0] lag_i,
    output logic       busy_o,
    output logic       nack_o,
    output logic       nreq_o,
    output logic       nwait_o,
    output logic [7:0] pdata_o,
    output logic [7:0] got_o,
    output int         got_n_o
);
    // idle levels of both directions
    initial
    begin
        busy_o = 1'b0;
        nack_o = 1'b1;
        nreq_o = 1'b1;
        nwait_o = 1'b1;
        pdata_o = 8'h00;
        got_o = 8'h00;
        got_n_o = 0;
    end
    ////////////////////////////////////////
    // forward: ack the strobe, latch on its return, then go idle
    always @(negedge host_clk_i)
    begin
        repeat (lag_i) @(posedge sys_clk_i);
        #5 busy_o = 1'b1;
        @(posedge host_clk_i);
        got_o = hdata_i;
        got_n_o++;
        #5 busy_o = 1'b0;
    end
    // reverse request, raised without regard to the clock
    always @(rev_i)
        #7 nreq_o = ~rev_i;
    // reverse: one byte for each send request
    always @(posedge send_i)
    begin
        wait (!host_ack_i);
        pdata_o = data_i;
        repeat (2) @(posedge sys_clk_i);
        #5 nack_o = 1'b0;
        wait (host_ack_i);
        repeat (lag_i) @(posedge sys_clk_i);
        #5 nack_o = 1'b1;
        wait (!host_ack_i);
        pdata_o = ~pdata_o;  // released lines no longer show the byte
    end
    // epp: answer a stretched cycle unless told to stall
    always @(negedge iochrdy_i)
    begin
        repeat (lag_i + 1) @(posedge sys_clk_i);
        pdata_o = data_i;
        if (!stall_i)
            #5 nwait_o = 1'b0;
        @(posedge iochrdy_i);
        #5 nwait_o = 1'b1;
        pdata_o = ~pdata_o;
    end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "ppe_consts.vh"
module tb_top;
    logic       sys_clk_i, arst_n_i, direction_control_bit_i, rev_req_i, tx_valid_i;
    logic       nior_i, niow_i, rev, send, stall;
    logic [2:0] mode_i;
    logic [3:0] lag;
    logic [7:0] tx_data_i, rev_data;
    wire  [7:0] rx_data_o, pd_o, pdata, got;
    wire        tx_ready_o, rx_valid_o, iochrdy_o, epp_timeout_o, pd_oe_o, host_clk_o;
    wire        host_clk_oe_o, host_ack_line_o, host_ack_line_oe_o, nwrite_o, periph_req_o;
    wire        busy_i, nack_i, nperiph_req_i, nwait_i;
    wire [31:0] got_n;
    int         fail_count, checks_done, cyc, n, seen;
    // pin levels: undriven open-collector lines sit at the pull-up
    wire [7:0]  pd_bus     = pd_oe_o ? pd_o : pdata;
    wire        strobe_pin = host_clk_oe_o ? host_clk_o : 1'b1;
    wire        hack_pin   = host_ack_line_oe_o ? host_ack_line_o : 1'b1;
    ppe_port dut (
        .sys_clk_i, .arst_n_i, .mode_i, .direction_control_bit_i, .rev_req_i, .tx_data_i,
        .tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .nior_i, .niow_i, .iochrdy_o,
        .epp_timeout_o, .pd_i(pd_bus), .pd_o, .pd_oe_o, .host_clk_o, .host_clk_oe_o,
        .host_ack_line_o, .host_ack_line_oe_o, .nwrite_o, .busy_i, .nack_i, .nperiph_req_i,
        .nwait_i, .periph_req_o
    );
    ppe_periph_model peer (
        .sys_clk_i, .host_clk_i(strobe_pin), .host_ack_i(hack_pin), .iochrdy_i(iochrdy_o),
        .hdata_i(pd_bus), .rev_i(rev), .send_i(send), .data_i(rev_data), .stall_i(stall),
        .lag_i(lag), .busy_o(busy_i), .nack_o(nack_i), .nreq_o(nperiph_req_i),
        .nwait_o(nwait_i), .pdata_o(pdata), .got_o(got), .got_n_o(got_n)
    );
    ////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp);
        checks_done++;
        if (seen_v !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen_v);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk_i);
        #2;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // push one byte once the fifo has room
    task automatic push(input logic [7:0] d);
        for (n = 0; n < 500 && tx_ready_o !== 1'b1; n++)
            step(1);
        tx_data_i = d;
        tx_valid_i = 1'b1;
        step(1);
        tx_valid_i = 1'b0;
        step(1);
    endtask
    // take k bytes at the peripheral and compare them in order
    task automatic drain(input int k, input logic [7:0] first);
        for (int i = 0; i < k; i++)
        begin
            for (n = 0; n < 500 && got_n <= seen; n++)
                step(1);
            check("fwd_byte", got, first + i[7:0]);
            seen++;
        end
    endtask
    // wait for the ready line to reach a level, counting cycles
    task automatic wait_rdy(input logic lvl);
        for (n = 0; n < 400 && iochrdy_o !== lvl; n++)
            step(1);
    endtask
    task automatic t_reset;
        check("host_clk", host_clk_o, 1'b1);
        check("host_ack", host_ack_line_o, 1'b0);
        check("nwrite", nwrite_o, 1'b1);
        check("iochrdy", iochrdy_o, 1'b1);
        $display("test reset done");
    endtask
    // slow peripheral: fill until refused, then drain; nack never moves
    task automatic t_fifo;
        int k;
        mode_i = `PPE_MODE_FIFO;
        lag = 4'd12;
        k = 0;
        step(2);
        while (tx_ready_o === 1'b1 && k < 12)
        begin
            push(8'h30 + k[7:0]);
            k++;
        end
        check("fifo_refused", k >= 8 && k <= 10, 1'b1);
        drain(k, 8'h30);
        check("fwd_idle", host_clk_o, 1'b1);
        $display("test fifo done");
    endtask
    task automatic t_ecp;
        mode_i = `PPE_MODE_ECP;
        lag = 4'd0;
        step(10);
        check("ecp_clk_oe", host_clk_oe_o, 1'b1);
        check("ecp_ack_oe", host_ack_line_oe_o, 1'b1);
        push(8'h5a);
        push(8'h5b);
        drain(2, 8'h5a);
        mode_i = `PPE_MODE_COMPAT;
        step(10);
        check("compat_clk_oe", host_clk_oe_o, 1'b0);
        check("compat_pin", strobe_pin, 1'b1);
        $display("test ecp forward done");
    endtask
    task automatic t_rev;
        mode_i = `PPE_MODE_ECP;
        rev_req_i = 1'b1;
        rev = 1'b1;
        step(10);
        check("periph_req", periph_req_o, 1'b1);
        check("rev_idle_ack", host_ack_line_o, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            rev_data = 8'hc3 + i[7:0];
            send = 1'b1;
            step(1);
            send = 1'b0;
            for (n = 0; n < 300 && rx_valid_o !== 1'b1; n++)
                step(1);
            check("rev_byte", rx_data_o, rev_data);
            step(1);
            check("rev_ack_low", host_ack_line_o, 1'b0);
        end
        rev = 1'b0;
        rev_req_i = 1'b0;
        step(10);
        $display("test reverse done");
    endtask
    task automatic t_epp;
        mode_i = `PPE_MODE_EPP;
        direction_control_bit_i = 1'b0;
        rev_data = 8'h96;
        step(4);
        niow_i = 1'b0;
        wait_rdy(1'b0);
        check("write_dir", nwrite_o, 1'b0);
        wait_rdy(1'b1);
        niow_i = 1'b1;
        step(6);
        check("write_dir_idle", nwrite_o, 1'b1);
        direction_control_bit_i = 1'b1;
        nior_i = 1'b0;
        for (n = 0; n < 300 && rx_valid_o !== 1'b1; n++)
            step(1);
        check("epp_read", rx_data_o, 8'h96);
        check("read_dir", nwrite_o, 1'b1);
        step(2);
        nior_i = 1'b1;
        step(6);
        stall = 1'b1;
        nior_i = 1'b0;
        wait_rdy(1'b0);
        wait_rdy(1'b1);
        check("epp_timeout", epp_timeout_o, 1'b1);
        check("tmo_window", n >= 180 && n <= 220, 1'b1);
        nior_i = 1'b1;
        stall = 1'b0;
        step(6);
        $display("test epp done");
    endtask
    initial
    begin
        arst_n_i = 1'b0;
        mode_i = `PPE_MODE_COMPAT;
        direction_control_bit_i = 1'b1;
        rev_req_i = 1'b0;
        tx_valid_i = 1'b0;
        tx_data_i = 8'h00;
        nior_i = 1'b1;
        niow_i = 1'b1;
        rev = 1'b0;
        send = 1'b0;
        stall = 1'b0;
        lag = 4'd0;
        rev_data = 8'h00;
        step(6);
        arst_n_i = 1'b1;
        step(3);
        t_reset();
        t_fifo();
        t_ecp();
        t_rev();
        t_epp();
        close_out();
    end
endmodule
// checker rides on every port instance
bind ppe_port ppe_port_properties #(.DATA_W(DATA_W)) chk (
    .sys_clk_i, .arst_n_i, .mode_i, .niow_i, .busy_i, .nack_i, .nwait_i, .pd_o, .pd_oe_o,
    .host_clk_o, .host_clk_oe_o, .host_ack_line_o, .nwrite_o, .iochrdy_o, .epp_timeout_o,
    .rx_valid_o
);
